// >>> src/omb_defs.svh
/*
 * Constants of the ordinary memory bus interface: area codes, access
 * size codes, line size and the software wait lookup.
 * Assumes little-endian byte lanes and a 32-bit physical address.
 */
`ifndef OMB_DEFS_SVH
`define OMB_DEFS_SVH

// Area field position in the physical address
`define OMB_AREA_HI    28
`define OMB_AREA_LO    26
`define OMB_AREA4      3'h4
`define OMB_AREA5      3'h5
`define OMB_AREA6      3'h6
// Card space split: low half memory card, high half I/O card
`define OMB_IO_BIT     25
`define OMB_ADDR_W     26

// Size and width codes; zero reads as longword
`define OMB_SZ_NONE    2'h0
`define OMB_SZ_BYTE    2'h1
`define OMB_SZ_WORD    2'h2
`define OMB_SZ_LONG    2'h3

// Cache line transfer
`define OMB_LINE_BYTES 5'h10
`define OMB_LINE_MASK  32'hFFFFFFF0

// Wait cycles by code {extra bit, field}: 0..10 plain, up to 38 for cards
`define OMB_WAIT_TAB   {6'h26, 6'h22, 6'h1E, 6'h1A, 6'h16, 6'h12, 6'h0E, 6'h0C, \
                        6'h0A, 6'h08, 6'h06, 6'h04, 6'h03, 6'h02, 6'h01, 6'h00}
`define OMB_CNT_ONE    6'h01
`define OMB_CNT_ZERO   6'h00

`endif

// >>> src/omb_pkg.sv
/*
 * Types of the ordinary memory bus interface.
 * Assumes nothing beyond the constants header.
 */
package omb_pkg;

    // Bus cycle states, one-hot
    typedef enum logic [5:0] {
        OMB_IDLE  = 6'h01,
        OMB_T1    = 6'h02,
        OMB_SETUP = 6'h04,
        OMB_WAIT  = 6'h08,
        OMB_T2    = 6'h10,
        OMB_HOLD  = 6'h20
    } omb_state_t;

endpackage

// >>> src/omb_ordinary_bus.sv
/*
 * Ordinary memory bus interface for areas 4 to 6: area decode, chip
 * selects, read strobe, byte write strobes, card enables and card I/O
 * strobes, software waits, card setup/hold and external wait sampling.
 * Assumes a core that holds its request steady until done_o, and static
 * memories or cards on the pins; configuration inputs come from
 * registers on the same clock.
 */
`timescale 1ns/1ps
`include "omb_defs.svh"

module omb_ordinary_bus (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // Core request
    input  wire logic                   req_i,
    input  wire logic [31:0]            addr_i,
    input  wire logic                   write_i,
    input  wire logic [1:0]             size_i,
    input  wire logic                   burst_i,
    input  wire logic                   dma16_i,
    input  wire logic [127:0]           wdata_i,
    // Core answer
    output logic                        ready_o,
    output logic                        beat_ack_o,
    output logic                        done_o,
    output logic                        err_o,
    output logic [31:0]                 rdata_o,
    // Area configuration
    input  wire logic [1:0]             area4_width_field_i,
    input  wire logic [2:0]             area4_wait_field_i,
    input  wire logic [1:0]             area5_width_field_i,
    input  wire logic [2:0]             area5_wait_field_i,
    input  wire logic                   area5_card_mode_i,
    input  wire logic                   area5_card_wait_extra_bit_i,
    input  wire logic [2:0]             area5_strobe_delay_field_i,
    input  wire logic [2:0]             area5_strobe_hold_field_i,
    input  wire logic [1:0]             area6_width_field_i,
    input  wire logic [2:0]             area6_wait_field_i,
    input  wire logic                   area6_card_mode_i,
    input  wire logic                   area6_card_wait_extra_bit_i,
    input  wire logic [2:0]             area6_strobe_delay_field_i,
    input  wire logic [2:0]             area6_strobe_hold_field_i,
    input  wire logic                   wait_edge_select_i,
    // Memory pins
    output logic [`OMB_ADDR_W-1:0]      addr_o,
    output logic                        area4_chip_select_n_o,
    output logic                        area5_chip_select_n_o,
    output logic                        area6_chip_select_n_o,
    output logic                        read_strobe_n_o,
    output logic [3:0]                  byte_write_strobe_n_o,
    output logic                        bus_start_strobe_n_o,
    // Card pins
    output logic                        card_a_enable_low_n_o,
    output logic                        card_a_enable_high_n_o,
    output logic                        card_b_enable_low_n_o,
    output logic                        card_b_enable_high_n_o,
    output logic                        card_io_read_strobe_n_o,
    output logic                        card_io_write_strobe_n_o,
    // Data and wait pins
    input  wire logic [31:0]            data_i,
    output logic [31:0]                 data_o,
    output logic                        data_oe_n_o,
    input  wire logic                   ext_wait_n_i
);

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Bytes moved by a size code
    function automatic logic [4:0] bytes_of(input logic [1:0] sz);
        logic [4:0] b;
        b = 5'h4;
        if (sz == `OMB_SZ_BYTE) begin
            b = 5'h1;
        end else if (sz == `OMB_SZ_WORD) begin
            b = 5'h2;
        end
        return b;
    endfunction

    // Unused code zero counts as longword
    function automatic logic [1:0] norm_sz(input logic [1:0] sz);
        return (sz == `OMB_SZ_NONE) ? `OMB_SZ_LONG : sz;
    endfunction

    // Wait cycles for a four-bit wait code
    function automatic logic [5:0] wait_cycles(input logic [3:0] code);
        logic [95:0] tab;
        tab = `OMB_WAIT_TAB;
        return tab[6*code +: 6];
    endfunction

    // Lane pattern of an access at lane zero
    function automatic logic [3:0] lane_base(input logic [1:0] sz);
        logic [3:0] m;
        m = 4'hF;
        if (sz == `OMB_SZ_BYTE) begin
            m = 4'h1;
        end else if (sz == `OMB_SZ_WORD) begin
            m = 4'h3;
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State and transfer context

    omb_pkg::omb_state_t state;
    omb_pkg::omb_state_t next_state;
    logic [5:0]          cnt;
    logic [5:0]          next_cnt;
    logic [31:0]         cur_addr;
    logic [31:0]         next_addr;
    logic [4:0]          beats_left;
    logic [4:0]          next_beats;
    logic [2:0]          area;
    logic                card;
    logic                wr;
    logic [1:0]          width;
    logic [1:0]          tsize;
    logic [5:0]          wcnt;
    logic [2:0]          ted;
    logic [2:0]          teh;
    logic                ign;
    logic                bs;
    logic                stb;
    logic                t2_late;

    // Wait pin synchronisers, rising and falling edge
    logic                wp1;
    logic                wp2;
    logic                wp3;
    logic                wait_pos;
    logic                wn1;
    logic                wn2;
    logic                wn3;
    logic                wait_neg;

    ////////////////////////////////////////////////////////////////////////
    // Request decode

    wire [2:0] req_area = addr_i[`OMB_AREA_HI:`OMB_AREA_LO];       // Upper bits are shadows
    wire       hit4     = (req_area == `OMB_AREA4);
    wire       hit5     = (req_area == `OMB_AREA5);
    wire       hit6     = (req_area == `OMB_AREA6);
    wire       hit_any  = hit4 | hit5 | hit6;

    // Area 4 never takes the card path
    wire       req_card = (hit5 & area5_card_mode_i) | (hit6 & area6_card_mode_i);

    // Width: cards stop at word
    wire [1:0] raw_w    = hit4 ? area4_width_field_i : (hit5 ? area5_width_field_i : area6_width_field_i);
    wire [1:0] norm_w   = norm_sz(raw_w);
    wire [1:0] req_w    = (req_card && norm_w == `OMB_SZ_LONG) ? `OMB_SZ_WORD : norm_w;

    // Wait code; the extra bit only counts for cards
    wire [2:0] req_wf   = hit4 ? area4_wait_field_i : (hit5 ? area5_wait_field_i : area6_wait_field_i);
    wire       req_wx   = req_card & (hit5 ? area5_card_wait_extra_bit_i : area6_card_wait_extra_bit_i);
    wire [5:0] req_wcnt = wait_cycles({req_wx, req_wf});

    // Card setup and hold fields
    wire [2:0] req_ted  = req_card ? (hit5 ? area5_strobe_delay_field_i : area6_strobe_delay_field_i) : 3'h0;
    wire [2:0] req_teh  = req_card ? (hit5 ? area5_strobe_hold_field_i : area6_strobe_hold_field_i) : 3'h0;

    // Line transfers use longword units, others their own size
    wire [1:0] req_ts   = burst_i ? `OMB_SZ_LONG : norm_sz(size_i);
    wire [4:0] req_tot  = burst_i ? `OMB_LINE_BYTES : bytes_of(req_ts);
    wire [4:0] req_wb   = bytes_of(req_w);
    wire [4:0] req_bts  = 5'((req_tot + req_wb - 5'h1) >> (req_w - `OMB_SZ_BYTE));
    wire [31:0] req_adr = burst_i ? (addr_i & `OMB_LINE_MASK) : addr_i;
    wire       req_ign  = dma16_i | (burst_i & write_i);

    ////////////////////////////////////////////////////////////////////////
    // Beat decode

    wire [1:0] beat_sz  = (wr && tsize < width) ? tsize : width;
    wire [4:0] beat_b   = bytes_of(beat_sz);
    wire [1:0] wmask    = 2'(bytes_of(width) - 5'h1);
    wire [1:0] bmask    = 2'(beat_b - 5'h1);
    wire [1:0] lane_ofs = cur_addr[1:0] & wmask & ~bmask;
    wire [3:0] lanes    = 4'(lane_base(beat_sz) << lane_ofs);
    wire       io_sp    = card & cur_addr[`OMB_IO_BIT];
    wire       has_hold = card & (teh != 3'h0);
    wire       has_setup = card & (ted != 3'h0);
    wire       cnt_last = (cnt == `OMB_CNT_ONE);
    wire       wait_seen = wait_edge_select_i ? ~wait_neg : ~wait_pos;
    wire       leave_beat = (state == omb_pkg::OMB_T2 & ~has_hold) |
                            (state == omb_pkg::OMB_HOLD & cnt_last);
    wire       last_beat = (beats_left == 5'h1);
    wire       take     = req_i & ready_o;
    wire [3:0] next_ofs = next_addr[3:0] & ~{2'h0, 2'(bytes_of(state == omb_pkg::OMB_IDLE ? req_w : width)
                                                    - 5'h1)};

    ////////////////////////////////////////////////////////////////////////
    // Cycle sequencer

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_addr  = cur_addr;
        next_beats = beats_left;
        case (state)
            omb_pkg::OMB_IDLE: begin
                if (req_i && hit_any) begin
                    next_state = omb_pkg::OMB_T1;
                    next_addr  = req_adr;
                    next_beats = req_bts;
                end
            end
            omb_pkg::OMB_T1: begin
                if (has_setup) begin
                    next_state = omb_pkg::OMB_SETUP;
                    next_cnt   = {3'h0, ted};
                end else if (wcnt != `OMB_CNT_ZERO) begin
                    next_state = omb_pkg::OMB_WAIT;
                    next_cnt   = wcnt;
                end else begin
                    next_state = omb_pkg::OMB_T2;
                end
            end
            omb_pkg::OMB_SETUP: begin
                if (!cnt_last) begin
                    next_cnt = cnt - `OMB_CNT_ONE;
                end else if (wcnt != `OMB_CNT_ZERO) begin
                    next_state = omb_pkg::OMB_WAIT;
                    next_cnt   = wcnt;
                end else begin
                    next_state = omb_pkg::OMB_T2;
                end
            end
            omb_pkg::OMB_WAIT: begin
                if (!cnt_last) begin
                    next_cnt = cnt - `OMB_CNT_ONE;
                end else if (!(wait_seen && !ign)) begin
                    next_state = omb_pkg::OMB_T2;
                end
            end
            omb_pkg::OMB_T2: begin
                if (has_hold) begin
                    next_state = omb_pkg::OMB_HOLD;
                    next_cnt   = {3'h0, teh};
                end
            end
            omb_pkg::OMB_HOLD: begin
                if (!cnt_last) begin
                    next_cnt = cnt - `OMB_CNT_ONE;
                end
            end
            default: begin
                next_state = omb_pkg::OMB_IDLE;
            end
        endcase
        // Next beat follows at once; the bus is kept to the end
        if (leave_beat) begin
            next_addr  = cur_addr + {27'h0, beat_b};
            next_beats = beats_left - 5'h1;
            next_state = last_beat ? omb_pkg::OMB_IDLE : omb_pkg::OMB_T1;
        end
    end

    // Sequencer registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state      <= omb_pkg::OMB_IDLE;
            cnt        <= `OMB_CNT_ZERO;
            cur_addr   <= 32'h0;
            beats_left <= 5'h0;
        end else begin
            state      <= next_state;
            cnt        <= next_cnt;
            cur_addr   <= next_addr;
            beats_left <= next_beats;
        end
    end

    // Transfer context, caught when a request is taken
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            area  <= 3'h0;
            card  <= 1'b0;
            wr    <= 1'b0;
            width <= `OMB_SZ_LONG;
            tsize <= `OMB_SZ_LONG;
            wcnt  <= `OMB_CNT_ZERO;
            ted   <= 3'h0;
            teh   <= 3'h0;
            ign   <= 1'b0;
        end else if (take && hit_any) begin
            area  <= req_area;
            card  <= req_card;
            wr    <= write_i;
            width <= req_w;
            tsize <= req_ts;
            wcnt  <= req_wcnt;
            ted   <= req_ted;
            teh   <= req_teh;
            ign   <= req_ign;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core answers

    assign ready_o = (state == omb_pkg::OMB_IDLE);

    // Beat data, beat and end pulses
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o    <= 32'h0;
            beat_ack_o <= 1'b0;
            done_o     <= 1'b0;
            err_o      <= 1'b0;
        end else begin
            if (state == omb_pkg::OMB_T2) begin
                rdata_o <= data_i;
            end
            beat_ack_o <= (state == omb_pkg::OMB_T2);
            done_o     <= (leave_beat & last_beat) | (take & ~hit_any);
            err_o      <= take & ~hit_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin timing

    // Address, bus start and write data change on the rising edge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_o      <= '0;
            bs          <= 1'b0;
            data_o      <= 32'h0;
            data_oe_n_o <= 1'b1;
        end else begin
            addr_o      <= next_addr[`OMB_ADDR_W-1:0];
            bs          <= (next_state == omb_pkg::OMB_T1);
            data_oe_n_o <= ~((next_state != omb_pkg::OMB_IDLE) &
                             (state == omb_pkg::OMB_IDLE ? write_i : wr));
            if (next_state == omb_pkg::OMB_T1) begin
                data_o <= 32'(wdata_i >> {next_ofs, 3'h0});
            end
        end
    end

    // Strobe window seen from the rising edge; it closes halfway through the
    // second state, before the address moves on to the next beat
    wire stb_phase = (state == omb_pkg::OMB_T1 & ~has_setup) |
                     (state == omb_pkg::OMB_SETUP & cnt_last) |
                     (state == omb_pkg::OMB_WAIT);

    // Falling edge copies give the half-cycle offsets
    always_ff @(negedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stb     <= 1'b0;
            t2_late <= 1'b0;
        end else begin
            stb     <= stb_phase;
            t2_late <= (state == omb_pkg::OMB_T2);
        end
    end

    // Plain memory select drops halfway through the second state
    wire cs_on = (state != omb_pkg::OMB_IDLE) &
                 ~(~card & state == omb_pkg::OMB_T2 & t2_late);

    // Area chip selects
    assign area4_chip_select_n_o = ~(cs_on & area == `OMB_AREA4);
    assign area5_chip_select_n_o = ~(cs_on & ~card & area == `OMB_AREA5);
    assign area6_chip_select_n_o = ~(cs_on & ~card & area == `OMB_AREA6);

    // Card enables by byte lane
    assign card_a_enable_low_n_o  = ~(cs_on & card & area == `OMB_AREA5 & lanes[0]);
    assign card_a_enable_high_n_o = ~(cs_on & card & area == `OMB_AREA5 & lanes[1]);
    assign card_b_enable_low_n_o  = ~(cs_on & card & area == `OMB_AREA6 & lanes[0]);
    assign card_b_enable_high_n_o = ~(cs_on & card & area == `OMB_AREA6 & lanes[1]);

    // Read and write strobes
    assign read_strobe_n_o          = ~(stb & ~wr & ~io_sp);
    assign byte_write_strobe_n_o    = ~(({4{stb & wr & ~card}} & lanes) |
                                        {2'h0, stb & wr & card & ~io_sp, 1'b0});
    assign card_io_read_strobe_n_o  = ~(stb & ~wr & io_sp);
    assign card_io_write_strobe_n_o = ~(stb & wr & io_sp);
    assign bus_start_strobe_n_o     = ~bs;

    ////////////////////////////////////////////////////////////////////////
    // External wait input

    // Rising edge chain; level moves when stages two and three agree
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wp1      <= 1'b1;
            wp2      <= 1'b1;
            wp3      <= 1'b1;
            wait_pos <= 1'b1;
        end else begin
            wp1 <= ext_wait_n_i;
            wp2 <= wp1;
            wp3 <= wp2;
            if (wp2 == wp3) begin
                wait_pos <= wp3;
            end
        end
    end

    // Falling edge chain; a missed edge is taken at the next one
    always_ff @(negedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wn1      <= 1'b1;
            wn2      <= 1'b1;
            wn3      <= 1'b1;
            wait_neg <= 1'b1;
        end else begin
            wn1 <= ext_wait_n_i;
            wn2 <= wn1;
            wn3 <= wn2;
            if (wn2 == wn3) begin
                wait_neg <= wn3;
            end
        end
    end

endmodule

// >>> verification/omb_sram_model.sv
/* Static memory model on the far side of the ordinary memory bus.
   Assumes one 32-bit device of 16 words and a bench that sets the stall length. */
`timescale 1ns/1ps
module omb_sram_model (
    // Pins from the controller
    input  wire logic        clk_i,
    input  wire logic [25:0] addr_i,
    input  wire logic        sel_n_i,
    input  wire logic        rd_n_i,
    input  wire logic [3:0]  we_n_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        bs_n_i,
    // Stall length from the bench
    input  wire logic [3:0]  hold_i,
    // Pins back to the controller
    output logic [31:0]      data_o,
    output logic             wait_n_o
);
    logic [31:0] mem [16];
    logic [31:0] last = 32'h0;
    logic [3:0]  pw   = 4'hF;
    logic [3:0]  cnt  = 4'h0;
    wire         en   = !sel_n_i && !rd_n_i;
    wire         en_d;
    ////////////////////////////////////////////////////////////
    // Output hold of 25 ns after release, then a changing pattern
    assign #25 en_d = en;
    assign data_o = (en || en_d) ? mem[addr_i[5:2]] : ~last;
    always @(posedge clk_i) begin
        last <= data_o;
    end
    // Byte lanes are written on the rising edge of their strobes
    always @(we_n_i) begin
        for (int i = 0; i < 4; i++)
            if (we_n_i[i] && !pw[i])
                mem[addr_i[5:2]][8*i+:8] = wdata_i[8*i+:8];
        pw = we_n_i;
    end
    // Stall from the first wait state on, late enough to be seen
    always @(posedge clk_i) begin
        if (!bs_n_i)
            cnt <= 4'h1;
        else if (cnt != 4'h0 && cnt != hold_i)
            cnt <= cnt + 4'h1;
        else
            cnt <= 4'h0;
    end
    assign wait_n_o = !(cnt != 4'h0 && hold_i != 4'h0);
endmodule

// >>> verification/omb_ordinary_bus_sva.sv
/* Concurrent checks on the ordinary memory bus pins.
   Assumes configuration is steady while a transfer runs. */
`timescale 1ns/1ps
module omb_ordinary_bus_sva (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Core side
    input wire logic        req_i,
    input wire logic [31:0] addr_i,
    input wire logic        write_i,
    input wire logic [1:0]  size_i,
    input wire logic        burst_i,
    input wire logic        ready_o,
    input wire logic        done_o,
    input wire logic        err_o,
    // Configuration
    input wire logic [1:0]  area4_width_field_i,
    input wire logic [2:0]  area4_wait_field_i,
    input wire logic        area5_card_mode_i,
    input wire logic        area6_card_mode_i,
    // Memory pins
    input wire logic        area4_chip_select_n_o,
    input wire logic        area5_chip_select_n_o,
    input wire logic        area6_chip_select_n_o,
    input wire logic        read_strobe_n_o,
    input wire logic [3:0]  byte_write_strobe_n_o,
    input wire logic        bus_start_strobe_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////
    // Accepted requests and their area
    wire       tk  = req_i & ready_o;
    wire [2:0] ar  = addr_i[28:26];
    wire [1:0] lo  = addr_i[1:0];
    wire       a4  = tk && ar == 3'h4 && !burst_i && area4_width_field_i == 2'h3;
    wire       a40 = a4 && area4_wait_field_i == 3'h0;
    // First and second state of a no-wait area 4 beat
    sequence s_first;
        !area4_chip_select_n_o && !bus_start_strobe_n_o;
    endsequence
    sequence s_second;
        area4_chip_select_n_o && bus_start_strobe_n_o;
    endsequence
    ////////////////////////////////////////////////////////////
    a_bs_single: assert property (
        $fell(bus_start_strobe_n_o) |=> bus_start_strobe_n_o) else $error("start strobe too long");
    a_area4_nowait: assert property (
        a40 |=> s_first ##1 s_second ##1 done_o) else $error("no-wait access timing wrong");
    a_area4_waits: assert property (
        a4 && area4_wait_field_i == 3'h7 |-> ##13 done_o) else $error("ten waits not inserted");
    a_write_lane: assert property (
        a40 && write_i && size_i == 2'h1 |=> byte_write_strobe_n_o == ~(4'h1 << $past(lo)))
        else $error("wrong byte strobe");
    a_read_full: assert property (
        a40 && !write_i |=> !read_strobe_n_o && byte_write_strobe_n_o == 4'hF) else $error("read strobes wrong");
    a_err_outside: assert property (
        tk && !(ar inside {3'h4, 3'h5, 3'h6}) |=> done_o && err_o) else $error("outside access not refused");
    a_area5_sel: assert property (
        tk && ar == 3'h5 && !area5_card_mode_i |=> !area5_chip_select_n_o && area4_chip_select_n_o)
        else $error("area 5 select wrong");
    a_area6_sel: assert property (
        tk && ar == 3'h6 && !area6_card_mode_i |=> !area6_chip_select_n_o && area5_chip_select_n_o)
        else $error("area 6 select wrong");
endmodule
bind omb_ordinary_bus omb_ordinary_bus_sva chk (.*);

// >>> verification/testbench.sv
/* Self-checking bench of the ordinary memory bus interface.
   Assumes the static memory model on the pins and a 25 MHz clock. */
`timescale 1ns/1ps
module testbench;
    // Core side and configuration
    logic         clk_i = 1'b0, rst_i = 1'b1, req_i = 1'b0, write_i = 1'b0;
    logic         burst_i = 1'b0, dma16_i = 1'b0, wait_edge_select_i = 1'b0, cm = 1'b0, xb = 1'b0;
    logic [31:0]  addr_i = 32'h0, rdata_o, data_i, data_o, rd;
    logic [1:0]   size_i = 2'h3, wid = 2'h3;
    logic [127:0] wdata_i = 128'h0;
    logic [2:0]   w4 = 3'h0, w5 = 3'h0, w6 = 3'h0;
    logic [3:0]   hold = 4'h0, byte_write_strobe_n_o;
    wire  [1:0]   area4_width_field_i = wid, area5_width_field_i = wid, area6_width_field_i = wid;
    wire  [2:0]   area4_wait_field_i = w4, area5_wait_field_i = w5, area6_wait_field_i = w6;
    wire          area5_card_mode_i = cm, area6_card_mode_i = cm;
    wire          area5_card_wait_extra_bit_i = xb, area6_card_wait_extra_bit_i = xb;
    wire  [2:0]   area5_strobe_delay_field_i = 3'h0, area5_strobe_hold_field_i = 3'h0;
    wire  [2:0]   area6_strobe_delay_field_i = 3'h0, area6_strobe_hold_field_i = 3'h0;
    // Design outputs
    logic         ready_o, beat_ack_o, done_o, err_o, data_oe_n_o, bus_start_strobe_n_o, read_strobe_n_o;
    logic         area4_chip_select_n_o, area5_chip_select_n_o, area6_chip_select_n_o, ext_wait_n_i;
    logic         card_a_enable_low_n_o, card_a_enable_high_n_o, card_b_enable_low_n_o, card_b_enable_high_n_o;
    logic         card_io_read_strobe_n_o, card_io_write_strobe_n_o;
    logic [25:0]  addr_o;
    int           error_cnt = 0, checks = 0, cyc = 0, n, bt, io;
    int           tab [8] = '{0, 1, 2, 3, 4, 6, 8, 10};
    wire          sel_n = area4_chip_select_n_o & area5_chip_select_n_o & area6_chip_select_n_o;
    ////////////////////////////////////////////////////////////
    omb_ordinary_bus uut (.*);
    omb_sram_model mem (.clk_i(clk_i), .addr_i(addr_o), .sel_n_i(sel_n), .rd_n_i(read_strobe_n_o),
        .we_n_i(byte_write_strobe_n_o), .wdata_i(data_o), .bs_n_i(bus_start_strobe_n_o),
        .hold_i(hold), .data_o(data_i), .wait_n_o(ext_wait_n_i));
    // Clock and hang guard
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            error_cnt++;
            results();
        end
    end
    // Compare, count and report
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One request held until done; n cycles after the take, bt beats
    task automatic acc(input logic [31:0] a, input logic w, input logic [1:0] sz, input logic [127:0] wd);
        @(posedge clk_i) #1;
        {addr_i, write_i, size_i, wdata_i, req_i} = {a, w, sz, wd, 1'b1};
        n = 0;
        bt = 0;
        io = 0;
        while (n < 200) begin
            @(posedge clk_i) #1;
            n++;
            bt += (beat_ack_o === 1'b1);
            io += (card_io_read_strobe_n_o === 1'b0);
            if (beat_ack_o === 1'b1)
                rd = rdata_o;
            if (done_o === 1'b1)
                break;
        end
        req_i = 1'b0;
        if (done_o !== 1'b1) begin
            error_cnt++;
            results();
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk_i);
        #1 rst_i = 1'b0;
        acc(32'h0000_0100, 0, 2'h3, 0);
        chk("refusal cycles", 1, n);
        chk("refusal flag", 1, err_o);
        acc(32'h1000_0010, 1, 2'h3, {96'h0, 32'hA5C3_1E77});
        chk("write cycles", 3, n);
        acc(32'h3000_0010, 0, 2'h3, 0);
        chk("shadow read", 32'hA5C3_1E77, rd);
        for (int i = 0; i < 4; i++)
            acc(32'h1000_0014 + 32'(i), 1, 2'h1, 128'(8'h30 + 8'(i)) << (32 + 8 * i));
        acc(32'h1000_0014, 0, 2'h1, 0);
        chk("byte lanes", 32'h3332_3130, rd);
        w4 = 3'h7;
        acc(32'h1000_0000, 0, 2'h3, 0);
        chk("area 4 waits", 13, n);
        $display("area 4 tests done");
        for (int c = 0; c < 16; c++) begin
            {w5, w6} = {2{3'(c)}};
            acc(c < 8 ? 32'h1400_0000 : 32'h1800_0000, 0, 2'h3, 0);
            chk("wait table", 32'(3 + tab[c % 8]), n);
        end
        $display("wait table tests done");
        {w5, hold} = {3'h5, 4'h8};
        acc(32'h1400_0000, 1, 2'h3, 0);
        chk("stretch rising", 1, n > 9);
        wait_edge_select_i = 1'b1;
        acc(32'h1400_0000, 0, 2'h3, 0);
        chk("stretch falling", 1, n > 9);
        {burst_i, dma16_i} = 2'b11;
        acc(32'h1400_0000, 0, 2'h3, 0);
        chk("dma line", 33, n);
        dma16_i = 1'b0;
        acc(32'h1400_0000, 1, 2'h3, 0);
        chk("write-back line", 33, n);
        $display("external wait tests done");
        {hold, w4, wid} = {4'h0, 3'h0, 2'h2};
        acc(32'h1000_0000, 0, 2'h3, 0);
        chk("fill beats", 8, bt);
        chk("fill pitch", 17, n);
        {burst_i, cm, xb, w5} = {1'b0, 1'b1, 1'b1, 3'h7};
        acc(32'h1600_0000, 0, 2'h2, 0);
        chk("card waits", 41, n);
        chk("io strobe", 39, io);
        $display("burst and card tests done");
        results();
    end
endmodule
